// ### rtl/pri_pkg.sv
// Constants, offsets and types of the peripheral register interface.
// Assumes a 16 KB peripheral window, word decode on address bits 13:2.
`default_nettype none
package pri_pkg;
    // Bus and channel geometry
    localparam int PRI_AW    = 14;
    localparam int PRI_DW    = 32;
    localparam int PRI_NCH   = 4;
    localparam int PRI_CNT_W = 16;

    // Register byte offsets inside the window
    localparam logic [13:0] PRI_OFF_CMD   = 14'h0000;
    localparam logic [13:0] PRI_OFF_CFG   = 14'h0004;
    localparam logic [13:0] PRI_OFF_STAT  = 14'h0008;
    localparam logic [13:0] PRI_OFF_IEN   = 14'h000C;
    localparam logic [13:0] PRI_OFF_IDIS  = 14'h0010;
    localparam logic [13:0] PRI_OFF_IMASK = 14'h0014;
    localparam logic [13:0] PRI_OFF_CHEN  = 14'h0018;
    localparam logic [13:0] PRI_OFF_CHDIS = 14'h001C;
    // Channel c: pointer at base + 8*c, count at base + 8*c + 4
    localparam logic [13:0] PRI_OFF_CHAN  = 14'h0100;

    // Command bits
    localparam int PRI_CMD_FLUSH = 0;
    localparam int PRI_CMD_HALT  = 1;
    // Configuration field: transfer size code
    localparam int PRI_CFG_SIZE_LSB = 0;
    localparam logic [1:0] PRI_SIZE_BYTE = 2'h0;
    localparam logic [1:0] PRI_SIZE_HALF = 2'h1;
    // Status fields
    localparam int PRI_ST_END_LSB  = 0;
    localparam int PRI_ST_BUSY_LSB = 4;
    localparam int PRI_ST_EN_LSB   = 8;

    // Reset values
    localparam logic [1:0]  PRI_CFG_RESET  = 2'h0;
    localparam logic [3:0]  PRI_MASK_RESET = 4'h0;
    localparam logic [3:0]  PRI_CHEN_RESET = 4'h0;
    localparam logic [31:0] PRI_PTR_RESET  = 32'h0000_0000;
    localparam logic [15:0] PRI_CNT_RESET  = 16'h0000;

    // Transfer engine states
    typedef enum logic {PRI_IDLE, PRI_BUSY} pri_state_t;
endpackage
`default_nettype wire

// ### rtl/pri_chan_if.sv
// Control and state of one transfer channel, between engine and channel.
// Assumes all signals are on the one system clock.
`timescale 1ns/100ps
`default_nettype none
interface pri_chan_if;
    logic [31:0] wdata;
    logic        wr_ptr;
    logic        wr_cnt;
    logic        flush;
    logic        step;
    logic [2:0]  inc;
    logic [31:0] ptr;
    logic [15:0] cnt;
    // Engine side
    modport ctl  (output wdata, wr_ptr, wr_cnt, flush, step, inc,
                  input ptr, cnt);
    // Channel side
    modport chan (input wdata, wr_ptr, wr_cnt, flush, step, inc,
                  output ptr, cnt);
endinterface
`default_nettype wire

// ### rtl/pri_chan.sv
// One transfer channel: memory pointer and transfer count.
// Assumes strobes are one-cycle pulses on the system clock.
`timescale 1ns/100ps
`default_nettype none
module pri_chan
    import pri_pkg::*;
(
    // Clock and reset
    input  wire logic   clk,
    input  wire logic   reset,
    // Engine connection
    pri_chan_if.chan    cb
);
    // Pointer: software write wins over a step in the same cycle
    always_ff @(posedge clk) begin
        if (reset || cb.flush) begin
            cb.ptr <= PRI_PTR_RESET;
        end else if (cb.wr_ptr) begin
            cb.ptr <= cb.wdata;
        end else if (cb.step && cb.cnt != PRI_CNT_RESET) begin
            cb.ptr <= cb.ptr + {29'h0, cb.inc};
        end
    end

    // Count: never wraps below zero
    always_ff @(posedge clk) begin
        if (reset || cb.flush) begin
            cb.cnt <= PRI_CNT_RESET;
        end else if (cb.wr_cnt) begin
            cb.cnt <= cb.wdata[15:0];
        end else if (cb.step && cb.cnt != PRI_CNT_RESET) begin
            cb.cnt <= cb.cnt - 16'h0001;
        end
    end
endmodule
`default_nettype wire

// ### rtl/pri_top.sv
// Register bank of a peripheral with four serial transfer channels.
// Assumes an APB (v2) master, an outside decoder driving PSEL for a
// 16 KB window, and serial-port and memory logic on SYS_CLK.
`timescale 1ns/100ps
`default_nettype none
module pri_top
    import pri_pkg::*;
(
    // Clock and reset
    input  wire logic               SYS_CLK,
    input  wire logic               RESET,
    // Peripheral bus
    input  wire logic               PSEL,
    input  wire logic               PENABLE,
    input  wire logic               PWRITE,
    input  wire logic [PRI_AW-1:0]  PADDR,
    input  wire logic [PRI_DW-1:0]  PWDATA,
    output logic      [PRI_DW-1:0]  PRDATA,
    // Interrupt source
    output logic                    IRQ,
    // Serial ports: rx0, tx0, rx1, tx1
    input  wire logic [PRI_NCH-1:0] SP_REQ,
    output logic      [PRI_NCH-1:0] SP_ACK,
    // Memory side of the transfer engine
    output logic                    MEM_REQ,
    output logic      [31:0]        MEM_ADDR,
    output logic                    MEM_WE,
    output logic      [1:0]         MEM_CH,
    input  wire logic               MEM_ACK
);
    // Bus phases
    logic        wr_access;
    logic        rd_setup;
    logic [11:0] word;
    logic        chan_hit;
    logic [1:0]  chan_sel;
    logic        chan_cnt;

    // Registers
    logic [1:0]  cfg_size;
    logic [3:0]  mask;
    logic [3:0]  chen;
    logic [3:0]  endf;
    logic [3:0]  busy;
    logic [31:0] status;
    logic [2:0]  inc;
    logic        cmd_flush;
    logic        cmd_halt;

    // Channel state gathered from the channel instances
    logic [31:0] ptr_arr [PRI_NCH];
    logic [15:0] cnt_arr [PRI_NCH];

    // Engine
    pri_state_t  state;
    logic [1:0]  cur;
    logic        grant_ok;
    logic [1:0]  grant_ch;
    logic [31:0] next_rdata;

    // Word decode ignores the byte lane bits
    assign word      = PADDR[13:2];
    assign wr_access = PSEL && PENABLE && PWRITE;
    assign rd_setup  = PSEL && !PENABLE && !PWRITE;
    assign chan_hit  = (PADDR[13:5] == PRI_OFF_CHAN[13:5]);
    assign chan_sel  = PADDR[4:3];
    assign chan_cnt  = PADDR[2];

    // Commands are pulses, nothing is stored
    assign cmd_flush = wr_access && word == PRI_OFF_CMD[13:2]
                       && PWDATA[PRI_CMD_FLUSH];
    assign cmd_halt  = wr_access && word == PRI_OFF_CMD[13:2]
                       && PWDATA[PRI_CMD_HALT];

    // Size code to pointer step; the spare code acts as a word
    always_comb begin
        case (cfg_size)
            PRI_SIZE_BYTE: inc = 3'h1;
            PRI_SIZE_HALF: inc = 3'h2;
            default:       inc = 3'h4;
        endcase
    end

    // Configuration register
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            cfg_size <= PRI_CFG_RESET;
        end else if (wr_access && word == PRI_OFF_CFG[13:2]) begin
            cfg_size <= PWDATA[PRI_CFG_SIZE_LSB +: 2];
        end
    end

    // Interrupt mask through enable and disable registers
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            mask <= PRI_MASK_RESET;
        end else if (wr_access && word == PRI_OFF_IEN[13:2]) begin
            mask <= mask | PWDATA[3:0];
        end else if (wr_access && word == PRI_OFF_IDIS[13:2]) begin
            mask <= mask & ~PWDATA[3:0];
        end
    end

    // Channel enables, shown in the status register
    always_ff @(posedge SYS_CLK) begin
        if (RESET || cmd_halt) begin
            chen <= PRI_CHEN_RESET;
        end else if (wr_access && word == PRI_OFF_CHEN[13:2]) begin
            chen <= chen | PWDATA[3:0];
        end else if (wr_access && word == PRI_OFF_CHDIS[13:2]) begin
            chen <= chen & ~PWDATA[3:0];
        end
    end

    // Channels; end flag is a level, so no set/clear race can lose it
    genvar c;
    generate
        for (c = 0; c < PRI_NCH; c++) begin : g_chan
            pri_chan_if cb ();

            assign cb.wdata  = PWDATA;
            assign cb.wr_ptr = wr_access && chan_hit
                               && chan_sel == 2'(c) && !chan_cnt;
            assign cb.wr_cnt = wr_access && chan_hit
                               && chan_sel == 2'(c) && chan_cnt;
            assign cb.flush  = cmd_flush;
            assign cb.inc    = inc;
            assign cb.step   = state == PRI_BUSY && MEM_ACK
                               && cur == 2'(c);
            assign ptr_arr[c] = cb.ptr;
            assign cnt_arr[c] = cb.cnt;
            assign endf[c]    = (cb.cnt == PRI_CNT_RESET);
            assign busy[c]    = state == PRI_BUSY && cur == 2'(c);

            pri_chan u_chan (
                .clk   (SYS_CLK),
                .reset (RESET),
                .cb    (cb)
            );
        end
    endgenerate

    // Status word; unused bits are zero
    always_comb begin
        status = 32'h0000_0000;
        status[PRI_ST_END_LSB  +: 4] = endf;
        status[PRI_ST_BUSY_LSB +: 4] = busy;
        status[PRI_ST_EN_LSB   +: 4] = chen;
    end

    // Lowest ready channel wins, so a port's receive beats its transmit, but tx0 beats rx1
    always_comb begin
        grant_ok = 1'b0;
        grant_ch = 2'h0;
        for (int i = PRI_NCH - 1; i >= 0; i--) begin
            if (chen[i] && SP_REQ[i] && cnt_arr[i] != PRI_CNT_RESET) begin
                grant_ok = 1'b1;
                grant_ch = i[1:0];
            end
        end
    end

    // Engine state; a transfer once started always completes
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            state <= PRI_IDLE;
            cur   <= 2'h0;
        end else begin
            case (state)
                PRI_IDLE: begin
                    if (grant_ok) begin
                        state <= PRI_BUSY;
                        cur   <= grant_ch;
                    end
                end
                PRI_BUSY: begin
                    if (MEM_ACK) begin
                        state <= PRI_IDLE;
                    end
                end
                default: begin
                    state <= PRI_IDLE;
                end
            endcase
        end
    end

    // Memory request, held until acknowledged
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            MEM_REQ  <= 1'b0;
            MEM_ADDR <= 32'h0000_0000;
            MEM_WE   <= 1'b0;
            MEM_CH   <= 2'h0;
        end else if (state == PRI_IDLE && grant_ok) begin
            MEM_REQ  <= 1'b1;
            MEM_ADDR <= ptr_arr[grant_ch];
            MEM_WE   <= !grant_ch[0]; // Receive writes memory
            MEM_CH   <= grant_ch;
        end else if (state == PRI_BUSY && MEM_ACK) begin
            MEM_REQ  <= 1'b0;
        end
    end

    // One-cycle done pulse back to the serial port
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            SP_ACK <= 4'h0;
        end else begin
            for (int i = 0; i < PRI_NCH; i++) begin
                SP_ACK[i] <= state == PRI_BUSY && MEM_ACK && cur == i[1:0];
            end
        end
    end

    // Interrupt from masked status
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= |(endf & mask);
        end
    end

    // Read data mux; write-only and unmapped words read zero
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (chan_hit) begin
            if (chan_cnt) begin
                next_rdata = {16'h0000, cnt_arr[chan_sel]};
            end else begin
                next_rdata = ptr_arr[chan_sel];
            end
        end else begin
            case (word)
                PRI_OFF_CFG[13:2]: begin
                    next_rdata = {30'h0, cfg_size};
                end
                PRI_OFF_STAT[13:2]: begin
                    next_rdata = status;
                end
                PRI_OFF_IMASK[13:2]: begin
                    next_rdata = {28'h0, mask};
                end
                default: begin
                    next_rdata = 32'h0000_0000;
                end
            endcase
        end
    end

    // Read data captured in setup phase, stable through access phase
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            PRDATA <= 32'h0000_0000;
        end else if (rd_setup) begin
            PRDATA <= next_rdata;
        end
    end
endmodule
`default_nettype wire

// ### verif/pri_top_monitor.sv
// Port-level checks of the peripheral register bank.
// Assumes the APB master and memory responder of the bench.
`timescale 1ns/100ps
`default_nettype none
module pri_top_monitor
(
    // Clock, reset and bus
    input wire logic        SYS_CLK,
    input wire logic        RESET,
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [13:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    // Interrupt, serial ports and memory
    input wire logic        IRQ,
    input wire logic [3:0]  SP_REQ,
    input wire logic [3:0]  SP_ACK,
    input wire logic        MEM_REQ,
    input wire logic [31:0] MEM_ADDR,
    input wire logic        MEM_WE,
    input wire logic [1:0]  MEM_CH,
    input wire logic        MEM_ACK
);
    default clocking @(posedge SYS_CLK); endclocking
    // Reset value check runs without a disable so it sees the release
    reset_quiet_a: assert property (
        RESET |=> !IRQ && !MEM_REQ && SP_ACK == 4'h0 && PRDATA == 32'h0)
        else $error("outputs not cleared by reset");
    cmd_reads_zero_a: assert property (disable iff (RESET)
        PSEL && !PENABLE && !PWRITE && PADDR[13:2] == 12'h000 |=> PRDATA == 32'h0)
        else $error("command register read not zero");
    mask_upper_zero_a: assert property (disable iff (RESET)
        PSEL && !PENABLE && !PWRITE && PADDR[13:2] == 12'h005 |=> PRDATA[31:4] == 28'h0)
        else $error("unused mask bits not zero");
    req_holds_a: assert property (disable iff (RESET)
        MEM_REQ && !MEM_ACK |=> MEM_REQ && $stable(MEM_ADDR) && $stable(MEM_CH))
        else $error("memory request dropped or changed early");
    ack_ends_a: assert property (disable iff (RESET)
        MEM_REQ && MEM_ACK |=> !MEM_REQ && SP_ACK == (4'h1 << $past(MEM_CH)))
        else $error("transfer end not reported to its channel");
    ack_pulse_a: assert property (disable iff (RESET)
        SP_ACK != 4'h0 |-> !MEM_REQ ##1 SP_ACK == 4'h0)
        else $error("serial ack not a lone pulse");
    dir_by_chan_a: assert property (disable iff (RESET)
        MEM_REQ |-> MEM_WE == !MEM_CH[0])
        else $error("memory direction wrong for channel");
    grant_needs_req_a: assert property (disable iff (RESET)
        $rose(MEM_REQ) |-> ($past(SP_REQ) & (4'h1 << MEM_CH)) != 4'h0)
        else $error("grant without serial request");
endmodule
bind pri_top pri_top_monitor mon_u (.SYS_CLK(SYS_CLK), .RESET(RESET), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .IRQ(IRQ), .SP_REQ(SP_REQ), .SP_ACK(SP_ACK), .MEM_REQ(MEM_REQ), .MEM_ADDR(MEM_ADDR),
    .MEM_WE(MEM_WE), .MEM_CH(MEM_CH), .MEM_ACK(MEM_ACK));
`default_nettype wire

// ### verif/pri_mem_model.sv
// Memory responder on the transfer engine's far side.
// Assumes one request at a time, answered after a chosen wait.
`timescale 1ns/100ps
`default_nettype none
module pri_mem_model
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       reset,
    // Request and answer
    input  wire logic       mem_req,
    input  wire logic [1:0] delay,
    output logic            mem_ack
);
    logic [1:0] waited;
    // Ack is a one-cycle pulse, only while a request stands
    always_ff @(posedge clk) begin
        if (reset || !mem_req || mem_ack) begin
            mem_ack <= 1'h0;
            waited  <= 2'h0;
        end else if (waited == delay) begin
            mem_ack <= 1'h1;
        end else begin
            waited <= waited + 2'h1;
        end
    end
endmodule
`default_nettype wire

// ### verif/tb.sv
// Self-checking bench for the peripheral register bank.
// Assumes the design, memory model and monitor are compiled first.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, gt) begin n_tests++; if ((gt) !== (ex)) begin bad_count++; \
    $display("wrong value %s exp %h got %h", nm, ex, gt); end end
module tb;
    import pri_pkg::*;
    logic        SYS_CLK = 1'h0, RESET = 1'h1, PSEL = 1'h0, PENABLE = 1'h0, PWRITE = 1'h0;
    logic [13:0] PADDR = 14'h0;
    logic [31:0] PWDATA = 32'h0, PRDATA, MEM_ADDR, d;
    logic [3:0]  SP_REQ = 4'h0, SP_ACK;
    logic        IRQ, MEM_REQ, MEM_WE, MEM_ACK;
    logic [1:0]  MEM_CH, slow = 2'h0;
    int          bad_count = 0, n_tests = 0, k;
    always #4 SYS_CLK = ~SYS_CLK;
    pri_top dut_u (.SYS_CLK(SYS_CLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .IRQ(IRQ),
        .SP_REQ(SP_REQ), .SP_ACK(SP_ACK), .MEM_REQ(MEM_REQ), .MEM_ADDR(MEM_ADDR),
        .MEM_WE(MEM_WE), .MEM_CH(MEM_CH), .MEM_ACK(MEM_ACK));
    pri_mem_model mem_u (.clk(SYS_CLK), .reset(RESET), .mem_req(MEM_REQ), .delay(slow),
        .mem_ack(MEM_ACK));
    // Bus cycles: setup then access, inputs moved 1 ns after the edge
    task wr(input logic [13:0] a, input logic [31:0] v);
        @(posedge SYS_CLK); #1 PSEL = 1'h1; PWRITE = 1'h1; PADDR = a; PWDATA = v;
        @(posedge SYS_CLK); #1 PENABLE = 1'h1;
        @(posedge SYS_CLK); #1 PSEL = 1'h0; PENABLE = 1'h0;
    endtask
    task chk_rd(input logic [13:0] a, input logic [31:0] ex);
        @(posedge SYS_CLK); #1 PSEL = 1'h1; PWRITE = 1'h0; PADDR = a;
        @(posedge SYS_CLK); #1 PENABLE = 1'h1;
        @(posedge SYS_CLK); d = PRDATA;
        #1 PSEL = 1'h0; PENABLE = 1'h0;
        `CHK("register read", ex, d)
    endtask
    task t_reset;
        chk_rd(PRI_OFF_CFG, 32'h0);
        chk_rd(PRI_OFF_IMASK, 32'h0);
        chk_rd(PRI_OFF_STAT, 32'h0000000F);
        chk_rd(PRI_OFF_CMD, 32'h0);
        chk_rd(14'h0200, 32'h0);
        chk_rd(14'h2008, 32'h0);
        $display("reset test done");
    endtask
    task t_regs;
        wr(PRI_OFF_CFG + 14'h1, 32'h00000003);
        chk_rd(PRI_OFF_CFG, 32'h00000003);
        wr(PRI_OFF_STAT, 32'h00000FFF);
        chk_rd(PRI_OFF_STAT, 32'h0000000F);
        wr(PRI_OFF_IEN, 32'h5);
        wr(PRI_OFF_IEN, 32'h0);
        chk_rd(PRI_OFF_IMASK, 32'h5);
        `CHK("irq", 1'h1, IRQ)
        wr(PRI_OFF_IDIS, 32'h4);
        chk_rd(PRI_OFF_IMASK, 32'h1);
        wr(PRI_OFF_IDIS, 32'h1);
        @(posedge SYS_CLK);
        #1 `CHK("irq", 1'h0, IRQ)
        wr(14'h010C, 32'h0000FFFF);
        chk_rd(14'h010C, 32'h0000FFFF);
        wr(14'h0108, 32'hFFFFFFFF);
        chk_rd(14'h0108, 32'hFFFFFFFF);
        chk_rd(PRI_OFF_STAT, 32'h0000000D);
        $display("register test done");
    endtask
    // Requests stand for a fixed span; done pulses looked at 1 ns after each edge
    task run(input logic [3:0] req, input int ex);
        k = 0;
        SP_REQ = req;
        repeat (60) begin
            @(posedge SYS_CLK);
            #1 if (SP_ACK !== 4'h0) k = k + 1;
        end
        SP_REQ = 4'h0;
        `CHK("transfer count", ex, k)
    endtask
    // Channel 1 requests too but stays disabled, so only channel 0 runs
    task t_xfer;
        wr(14'h0100, 32'h00001000);
        wr(14'h0104, 32'h2);
        wr(PRI_OFF_CFG, 32'h2);
        wr(PRI_OFF_CHEN, 32'h1);
        chk_rd(PRI_OFF_STAT, 32'h0000010C);
        wr(PRI_OFF_IEN, 32'h1);
        slow = 2'h2;
        run(4'h3, 2);
        chk_rd(14'h0100, 32'h00001008);
        chk_rd(14'h0104, 32'h0);
        `CHK("irq", 1'h1, IRQ)
        `CHK("mem addr", 32'h00001004, MEM_ADDR)
        `CHK("mem write", 1'h1, MEM_WE)
        // Half-word steps on the transmit channel of port 1
        wr(14'h0118, 32'h00002000);
        wr(14'h011C, 32'h2);
        wr(PRI_OFF_CFG, 32'h1);
        wr(PRI_OFF_CHEN, 32'h8);
        run(4'h8, 2);
        chk_rd(14'h0118, 32'h00002004);
        `CHK("mem write", 1'h0, MEM_WE)
        `CHK("mem chan", 2'h3, MEM_CH)
        // Byte step on the receive channel of port 1, memory answering at once
        wr(14'h0110, 32'h00003000);
        wr(14'h0114, 32'h1);
        wr(PRI_OFF_CFG, 32'h0);
        wr(PRI_OFF_CHEN, 32'h4);
        slow = 2'h0;
        run(4'h4, 1);
        chk_rd(14'h0110, 32'h00003001);
        `CHK("mem addr", 32'h00003000, MEM_ADDR)
        $display("transfer test done");
    endtask
    task t_cmd;
        wr(PRI_OFF_CMD, 32'h2);
        chk_rd(PRI_OFF_STAT, 32'h0000000D);
        wr(PRI_OFF_CHEN, 32'hF);
        wr(PRI_OFF_CHDIS, 32'h5);
        wr(PRI_OFF_CMD, 32'h0);
        chk_rd(PRI_OFF_STAT, 32'h00000A0D);
        wr(PRI_OFF_CMD, 32'h1);
        chk_rd(14'h0108, 32'h0);
        chk_rd(PRI_OFF_STAT, 32'h00000A0F);
        $display("command test done");
    endtask
    task test_done;
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge SYS_CLK);
        #1 RESET = 1'h0;
        t_reset;
        t_regs;
        t_xfer;
        t_cmd;
        // Second reset in mid-run must bring configuration, mask and status back
        RESET = 1'h1;
        repeat (3) @(posedge SYS_CLK);
        #1 RESET = 1'h0;
        t_reset;
        test_done;
    end
    // Watchdog well past the 350 or so cycles the tests need
    initial begin
        #100000;
        bad_count++;
        test_done;
    end
endmodule
`default_nettype wire
